// file: rtl/stw_exec.sv
// Execution core for trap, register transfer, test and wait instructions.
// Assumes byte-wide memory that answers reads in the cycle of the address.
`timescale 1ns/1ps
`default_nettype none
`include "stw_consts.svh"
module stw_exec (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic low_power_in,
  input wire logic irq_n_in,
  input wire logic timer_zero_in,
  input wire logic timer_irq_en_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [12:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_wr_out,
  output logic mem_rd_out,
  output logic [7:0] accumulator_reg_out,
  output logic [7:0] index_reg_out,
  output logic [7:0] flag_byte_out,
  output logic [12:0] pc_out,
  output logic [12:0] stack_ptr_out,
  output logic cpu_clk_en_out,
  output logic illegal_op_out
);
  typedef enum logic [3:0] {
    ST_FETCH, ST_DECODE, ST_OPERAND, ST_TEST_READ, ST_PAD,
    ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_VEC_END, ST_WAIT
  } stw_state_t;

  stw_wake_if wk ();
  logic irq_low;

  stw_wake_mon u_wake (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .irq_n_in(irq_n_in),
    .timer_zero_in(timer_zero_in),
    .timer_irq_en_in(timer_irq_en_in),
    .irq_low_out(irq_low),
    .wk(wk)
  );

  stw_state_t state, next_state;
  logic [7:0] acc, next_acc, idx, next_idx, cc, next_cc, opc, next_opc;
  logic [12:0] pc, next_pc, sp, next_sp, addr, next_addr, vec, next_vec;
  logic [2:0] push_n, next_push_n;
  logic [3:0] pad, next_pad;
  logic [7:0] wdata, next_wdata;
  logic wr, next_wr, rd, next_rd, clk_en, next_clk_en, ill, next_ill;

  function automatic logic [7:0] push_byte(input logic [2:0] n,
      input logic [12:0] p, input logic [7:0] x, input logic [7:0] a,
      input logic [7:0] c);
    unique case (n)
      3'h0: push_byte = p[7:0];
      3'h1: push_byte = {3'h0, p[12:8]};
      3'h2: push_byte = x;
      3'h3: push_byte = a;
      default: push_byte = {`STW_CC_TOP, c[4:0]};
    endcase
  endfunction

  function automatic logic [7:0] test_flags(input logic [7:0] c,
      input logic [7:0] v);
    logic [7:0] r;
    r = c;
    r[`STW_CC_N] = v[7];
    r[`STW_CC_Z] = (v == 8'h00);
    test_flags = r;
  endfunction

  always_comb begin
    next_state = state;
    next_acc = acc;
    next_idx = idx;
    next_cc = cc;
    next_opc = opc;
    next_pc = pc;
    next_sp = sp;
    next_addr = addr;
    next_vec = vec;
    next_push_n = push_n;
    next_pad = pad;
    next_wdata = wdata;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_clk_en = clk_en;
    next_ill = 1'b0;
    unique case (state)
      ST_FETCH: begin
        // Mask set: keep running the program, no interrupt service
        if (irq_low && !cc[`STW_CC_I]) begin
          next_vec = `STW_IRQ_VEC_HI;
          next_push_n = 3'h0;
          next_state = ST_PUSH;
        end else begin
          next_addr = pc;
          next_rd = 1'b1;
          next_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        next_opc = mem_rdata_in;
        next_pc = pc + 13'h0001;
        next_pad = `STW_SHORT_CYC - 4'h2;
        next_state = ST_PAD;
        unique case (mem_rdata_in)
          `STW_OP_A2X: next_idx = acc;
          `STW_OP_X2A: next_acc = idx;
          `STW_OP_TEST_ACC_INSTR: next_cc = test_flags(cc, acc);
          `STW_OP_TEST_INDEX_INSTR: next_cc = test_flags(cc, idx);
          `STW_OP_TSTI0: begin
            next_addr = {5'h00, idx};
            next_rd = 1'b1;
            next_state = ST_TEST_READ;
          end
          `STW_OP_TSTD, `STW_OP_TSTI1: begin
            next_addr = pc + 13'h0001;
            next_rd = 1'b1;
            next_state = ST_OPERAND;
          end
          `STW_OP_TRAP: begin
            next_vec = `STW_TRAP_VEC_HI;
            next_push_n = 3'h0;
            next_pad = low_power_in ? `STW_TRAP_CYC_LP - 4'h9 :
                                      `STW_TRAP_CYC_OLD - 4'h9;
            next_state = ST_PUSH;
          end
          `STW_OP_WAIT: begin
            if (low_power_in) begin
              next_cc[`STW_CC_I] = 1'b0;
              next_clk_en = 1'b0;
              next_state = ST_WAIT;
            end else begin
              next_ill = 1'b1;
              next_state = ST_FETCH;
            end
          end
          default: begin
            next_ill = 1'b1;
            next_state = ST_FETCH;
          end
        endcase
      end
      ST_OPERAND: begin
        next_pc = pc + 13'h0001;
        next_addr = (opc == `STW_OP_TSTD) ? {5'h00, mem_rdata_in} :
                    13'({5'h00, mem_rdata_in} + {5'h00, idx});
        next_rd = 1'b1;  // Read only, no write-back
        next_state = ST_TEST_READ;
      end
      ST_TEST_READ: begin
        next_cc = test_flags(cc, mem_rdata_in);
        next_state = ST_FETCH;
      end
      ST_PAD: begin
        if (pad == 4'h0) next_state = ST_FETCH;
        else next_pad = pad - 4'h1;
      end
      ST_PUSH: begin
        next_addr = sp;
        next_wdata = push_byte(push_n, pc, idx, acc, cc);
        next_wr = 1'b1;
        next_sp = sp - 13'h0001;
        next_push_n = push_n + 3'h1;
        if (push_n == 3'h4) begin
          next_cc[`STW_CC_I] = 1'b1;
          // Last byte must still land at the stack, not at the vector
          next_state = ST_VEC_HI;
        end
      end
      ST_VEC_HI: begin
        next_addr = vec;
        next_rd = 1'b1;
        next_state = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        next_pc = {mem_rdata_in[4:0], pc[7:0]};
        next_addr = vec + 13'h0001;
        next_rd = 1'b1;
        next_state = ST_VEC_END;
      end
      ST_VEC_END: begin
        next_pc = {pc[12:8], mem_rdata_in};
        // Trap pads out to its full length; wakes and reset go straight on
        if (pad == 4'h0) begin
          next_state = ST_FETCH;
        end else begin
          next_pad = pad - 4'h1;
          next_state = ST_PAD;
        end
      end
      ST_WAIT: begin
        if (wk.wake) begin
          next_clk_en = 1'b1;
          next_vec = (wk.cause == stw_pkg::STW_WAKE_IRQ) ?
                     `STW_IRQ_VEC_HI : `STW_TMR_VEC_HI;
          next_push_n = 3'h0;
          next_pad = 4'h0;
          next_state = ST_PUSH;
        end
      end
      default: next_state = ST_FETCH;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin  // Reset vector fetch on restart
      state <= ST_VEC_HI;
      acc <= 8'h00;
      idx <= 8'h00;
      cc <= `STW_CC_RESET;
      opc <= 8'h00;
      pc <= 13'h0000;
      sp <= `STW_SP_RESET;
      addr <= 13'h0000;
      vec <= `STW_RST_VEC_HI;
      push_n <= 3'h0;
      pad <= 4'h0;
      wdata <= 8'h00;
      wr <= 1'b0;
      rd <= 1'b0;
      clk_en <= 1'b1;
      ill <= 1'b0;
    end else begin
      state <= next_state;
      acc <= next_acc;
      idx <= next_idx;
      cc <= next_cc;
      opc <= next_opc;
      pc <= next_pc;
      sp <= next_sp;
      addr <= next_addr;
      vec <= next_vec;
      push_n <= next_push_n;
      pad <= next_pad;
      wdata <= next_wdata;
      wr <= next_wr;
      rd <= next_rd;
      clk_en <= next_clk_en;
      ill <= next_ill;
    end
  end

  always_comb begin
    mem_addr_out = addr;
    mem_wdata_out = wdata;
    mem_wr_out = wr;
    mem_rd_out = rd;
    accumulator_reg_out = acc;
    index_reg_out = idx;
    flag_byte_out = cc;
    pc_out = pc;
    stack_ptr_out = sp;
    cpu_clk_en_out = clk_en;
    illegal_op_out = ill;
  end
endmodule
`default_nettype wire

// file: rtl/stw_consts.svh
// Constants for the trap, transfer, test and wait execution block.
// Assumes an 8-bit core with a 13-bit address bus and one byte per access.
`ifndef STW_CONSTS_SVH
`define STW_CONSTS_SVH
`define STW_OP_TRAP 8'h83
`define STW_OP_A2X 8'h97
`define STW_OP_X2A 8'h9F
`define STW_OP_WAIT 8'h8F
`define STW_OP_TEST_ACC_INSTR 8'h4D
`define STW_OP_TEST_INDEX_INSTR 8'h5D
`define STW_OP_TSTD 8'h3D
`define STW_OP_TSTI0 8'h7D
`define STW_OP_TSTI1 8'h6D
`define STW_ADDR_ONES 13'h1FFF
`define STW_TRAP_VEC_HI (`STW_ADDR_ONES - 13'h0003)
`define STW_TRAP_VEC_LO (`STW_ADDR_ONES - 13'h0002)
`define STW_RST_VEC_HI (`STW_ADDR_ONES - 13'h0001)
`define STW_IRQ_VEC_HI (`STW_ADDR_ONES - 13'h0005)
`define STW_TMR_VEC_HI (`STW_ADDR_ONES - 13'h0007)
`define STW_SP_RESET 13'h007F
`define STW_CC_TOP 3'h7
`define STW_CC_H 4
`define STW_CC_I 3
`define STW_CC_N 2
`define STW_CC_Z 1
`define STW_CC_C 0
`define STW_CC_RESET 8'hE8
`define STW_TRAP_CYC_OLD 4'hB
`define STW_TRAP_CYC_LP 4'hA
`define STW_SHORT_CYC 4'h2
`endif

// file: rtl/stw_pkg.sv
// Types for the trap, transfer, test and wait execution block.
// Assumes the constants header is included by the files that need numbers.
package stw_pkg;
  typedef enum logic [1:0] {
    STW_WAKE_RESET,
    STW_WAKE_IRQ,
    STW_WAKE_TIMER
  } stw_wake_t;
endpackage

// file: rtl/stw_wake_if.sv
// Interface carrying wake requests from the wake monitor to the core.
// Assumes both ends share sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
interface stw_wake_if;
  logic wake;
  stw_pkg::stw_wake_t cause;
  modport mon (output wake, output cause);
  modport core (input wake, input cause);
endinterface
`default_nettype wire

// file: rtl/stw_wake_mon.sv
// Wake monitor: synchronises the external interrupt pin and picks a cause.
// Assumes irq_n_in is asynchronous; timer signals come from this clock.
`timescale 1ns/1ps
`default_nettype none
module stw_wake_mon (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic irq_n_in,
  input wire logic timer_zero_in,
  input wire logic timer_irq_en_in,
  output logic irq_low_out,
  stw_wake_if.mon wk
);
  logic irq_meta, irq_sync;
  logic next_irq_meta, next_irq_sync;

  always_comb begin
    next_irq_meta = irq_n_in;
    next_irq_sync = irq_meta;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
    end else begin
      irq_meta <= next_irq_meta;
      irq_sync <= next_irq_sync;
    end
  end

  assign irq_low_out = !irq_sync;

  // External line takes priority over the timer
  always_comb begin
    wk.wake = !irq_sync || (timer_zero_in && timer_irq_en_in);
    wk.cause = !irq_sync ? stw_pkg::STW_WAKE_IRQ : stw_pkg::STW_WAKE_TIMER;
  end
endmodule
`default_nettype wire

// file: verification/stw_mem_model.sv
// Program and stack memory on the core's byte bus.
// Assumes the bench preloads the array; reads answer in the address cycle.
`timescale 1ns/1ps
`default_nettype none
module stw_mem_model (
  input wire logic sys_clk_in,
  input wire logic [12:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  output logic [7:0] mem_rdata_out
);
  logic [7:0] mem [8192];
  always @(posedge sys_clk_in) begin
    if (mem_wr_in) begin
      mem[mem_addr_in] <= mem_wdata_in;
    end
  end
  // Unselected bus shows the inverse so a stray sample cannot pass by luck
  assign mem_rdata_out = mem_rd_in ? mem[mem_addr_in] : ~mem[mem_addr_in];
endmodule
`default_nettype wire

// file: verification/stw_exec_monitor.sv
// Port checker for the execution core, bound to its top module.
// Assumes stacking writes come as one unbroken burst.
`timescale 1ns/1ps
`default_nettype none
module stw_exec_monitor (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic low_power_in,
  input wire logic irq_n_in,
  input wire logic timer_zero_in,
  input wire logic timer_irq_en_in,
  input wire logic [12:0] mem_addr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic mem_wr_out,
  input wire logic mem_rd_out,
  input wire logic [7:0] flag_byte_out,
  input wire logic cpu_clk_en_out,
  input wire logic illegal_op_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  AST_STACK_DEC: assert property (mem_wr_out && $past(mem_wr_out)
    |-> mem_addr_out == $past(mem_addr_out) - 13'h0001)
    else $error("stack address not decremented");
  AST_FLAGS_TOP: assert property ($fell(mem_wr_out)
    |-> $past(mem_wdata_out[7:5]) == 3'h7)
    else $error("stacked flag byte top bits wrong");
  AST_TRAP_MASK: assert property ($fell(mem_wr_out)
    |-> ##[0:4] flag_byte_out[3])
    else $error("mask not set after stacking");
  AST_GATED_QUIET: assert property (!cpu_clk_en_out
    |-> !mem_rd_out && !mem_wr_out)
    else $error("bus access while clock gated");
  AST_WAIT_UNMASK: assert property ($fell(cpu_clk_en_out)
    |-> ##[0:2] !flag_byte_out[3])
    else $error("wait left mask set");
  AST_WAKE_IRQ: assert property (!cpu_clk_en_out && !irq_n_in
    |-> ##[1:6] cpu_clk_en_out)
    else $error("no wake on interrupt line");
  AST_WAKE_TMR: assert property (!cpu_clk_en_out && timer_zero_in
    && timer_irq_en_in |-> ##[1:6] cpu_clk_en_out)
    else $error("no wake on timer");
  AST_OLD_NO_WAIT: assert property (!low_power_in
    |-> cpu_clk_en_out)
    else $error("old variant gated its clock");
  cover property ($fell(cpu_clk_en_out));
  cover property ($fell(mem_wr_out));
  cover property (illegal_op_out);
endmodule
bind stw_exec stw_exec_monitor u_stw_exec_monitor (.sys_clk_in, .resetn_in,
  .low_power_in, .irq_n_in, .timer_zero_in, .timer_irq_en_in, .mem_addr_out,
  .mem_wdata_out, .mem_wr_out, .mem_rd_out, .flag_byte_out, .cpu_clk_en_out,
  .illegal_op_out);
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench: trap, transfers, tests, wait and both wakes.
// Assumes a memory model on the bus and no other traffic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic low_power_in = 1'b1;
  logic irq_n_in = 1'b1;
  logic timer_zero_in = 1'b0;
  logic timer_irq_en_in = 1'b0;
  logic [7:0] mem_rdata_in, mem_wdata_out, accumulator_reg_out;
  logic [7:0] index_reg_out, flag_byte_out, vk, v40, v00;
  logic [12:0] mem_addr_out, pc_out, stack_ptr_out;
  logic mem_wr_out, mem_rd_out, cpu_clk_en_out, illegal_op_out, n, z;
  int failures = 0;
  int n_tests = 0;
  logic [20:0] wq[$];
  // Vectors, the program at 0100 and the WAITs at 0200 and 0300; all else but the operands at 0000, 0020 and 0040 holds a harmless 5D
  logic [20:0] img[19] = '{21'h1F_FE01, 21'h1F_FF00, 21'h1F_FC02,
    21'h1F_FD00, 21'h1F_FA03, 21'h1F_FB00, 21'h1F_F804, 21'h1F_F900,
    21'h01_004D, 21'h01_013D, 21'h01_0240, 21'h01_0397, 21'h01_049F,
    21'h01_057D, 21'h01_066D, 21'h01_0720, 21'h01_0883, 21'h02_008F,
    21'h03_008F};
  always #4 sys_clk_in = ~sys_clk_in;
  stw_exec u_stw_exec (.sys_clk_in, .resetn_in, .low_power_in, .irq_n_in,
    .timer_zero_in, .timer_irq_en_in, .mem_rdata_in, .mem_addr_out,
    .mem_wdata_out, .mem_wr_out, .mem_rd_out, .accumulator_reg_out,
    .index_reg_out, .flag_byte_out, .pc_out, .stack_ptr_out,
    .cpu_clk_en_out, .illegal_op_out);
  stw_mem_model u_stw_mem_model (.sys_clk_in, .mem_addr_in(mem_addr_out),
    .mem_wdata_in(mem_wdata_out), .mem_wr_in(mem_wr_out),
    .mem_rd_in(mem_rd_out), .mem_rdata_out(mem_rdata_in));
  always @(negedge sys_clk_in) if (mem_wr_out === 1'b1)
    wq.push_back({mem_addr_out, mem_wdata_out});
  function automatic logic [7:0] rnd();
    return ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
  endfunction
  // Flags after a test while the mask is still set from reset
  function automatic logic [7:0] tst_flags(input logic [7:0] v);
    return {5'h1D, v[7], v == 8'h00, 1'b0};
  endfunction
  task automatic final_report();
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic lp);
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    low_power_in <= lp;
    irq_n_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
  endtask
  task automatic wait_en(input logic lvl);
    int i;
    i = 0;
    while (cpu_clk_en_out !== lvl && i < 300) begin
      @(negedge sys_clk_in);
      i++;
    end
    `CHK(cpu_clk_en_out, lvl, "clock enable level")
  endtask
  task automatic wait_pc(input logic [12:0] a);
    int k;
    k = 0;
    while (pc_out !== a && k < 300) begin
      @(negedge sys_clk_in);
      k++;
    end
    `CHK(pc_out, a, "program counter")
  endtask
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    int i;
    void'($urandom(8));
    for (i = 0; i < 8192; i++) u_stw_mem_model.mem[i] = 8'h5D;
    foreach (img[k]) u_stw_mem_model.mem[img[k][20:8]] = img[k][7:0];
    v40 = rnd();
    v00 = rnd();
    u_stw_mem_model.mem[13'h0040] = v40;
    u_stw_mem_model.mem[13'h0000] = v00;
    vk = rnd();
    u_stw_mem_model.mem[13'h0020] = vk;
    n = vk[7];
    z = (vk == 8'h00);
    do_reset(1'b1);
    wait_pc(13'h0102);
    `CHK(flag_byte_out, tst_flags(8'h00), "test acc flags")
    wait_pc(13'h0104);
    `CHK(flag_byte_out, tst_flags(v40), "test direct flags")
    wait_pc(13'h0108);
    `CHK(flag_byte_out, tst_flags(v00), "test indexed flags")
    wait_en(1'b0);
    `CHK(flag_byte_out[3], 1'b0, "wait kept mask")
    @(posedge sys_clk_in);
    irq_n_in <= 1'b0;
    wait_en(1'b1);
    @(posedge sys_clk_in);
    irq_n_in <= 1'b1;
    wait_en(1'b0);
    @(posedge sys_clk_in);
    timer_zero_in <= 1'b1;
    timer_irq_en_in <= 1'b1;
    wait_en(1'b1);
    @(posedge sys_clk_in);
    timer_zero_in <= 1'b0;
    // Line held low while the wake left the mask set: must not be served
    irq_n_in <= 1'b0;
    repeat (40) @(negedge sys_clk_in);
    `CHK(wq.size(), 15, "write count")
    for (i = 0; i < 15; i++) begin
      `CHK(wq[i][20:8], 13'h007F - 13'(i), "stack address")
    end
    for (i = 0; i < 3; i++) begin
      `CHK(wq[5*i][7:0], (i == 0) ? 8'h09 : 8'h01, "pc low")
      `CHK(wq[5*i+1][7:0], 8'(i + 1), "pc high")
      `CHK(wq[5*i+2][7:0], 8'h00, "stacked index")
      `CHK(wq[5*i+3][7:0], 8'h00, "stacked acc")
      `CHK(wq[5*i+4][7:0], {4'hE, i == 0, n, z, 1'b0}, "flags")
    end
    `CHK(stack_ptr_out, 13'h0070, "stack pointer")
    `CHK(pc_out[12:8], 5'h04, "timer vector")
    `CHK(flag_byte_out[3], 1'b1, "mask held off line")
    `CHK(accumulator_reg_out, 8'h00, "acc after copies")
    `CHK(index_reg_out, 8'h00, "index after copies")
    u_stw_mem_model.mem[13'h0100] = 8'h8F;
    do_reset(1'b0);
    i = 0;
    while (illegal_op_out !== 1'b1 && i < 100) begin
      @(negedge sys_clk_in);
      i++;
    end
    `CHK(illegal_op_out, 1'b1, "wait on old variant")
    `CHK(cpu_clk_en_out, 1'b1, "old variant gated")
    final_report();
  end
endmodule
`default_nettype wire
